// *** include/isc_defines.vh ***
/*
 image signature counters: register offsets, bit positions, counter limits, clock rates
 and counts. included by the design file; no logic here.
*/
`ifndef ISC_DEFINES_VH
`define ISC_DEFINES_VH
`define ISC_ADDR_W 32
`define ISC_OFS_FRAME_CTRL 32'hf1000610
`define ISC_OFS_FRAME_VAL 32'hf1000614
`define ISC_OFS_TRIG_CTRL 32'hf1000620
`define ISC_OFS_TRIG_VAL 32'hf1000624
`define ISC_OFS_SIG_CTRL 32'hf1000630
`define ISC_OFS_USER_WORD 32'hf1000634
`define ISC_OFS_FEATURE_CTRL 32'hf1000640
`define ISC_OFS_SEQ_SEL 32'hf1000650
`define ISC_OFS_LED_NV 32'hf1000654
`define ISC_BIT_PRESENT 31
`define ISC_BIT_RESET 30
`define ISC_BIT_SIG_ON 25
`define ISC_BIT_LED_INQ 30
`define ISC_BIT_LED_BLANK 14
`define ISC_SIG_BYTES 48
`define ISC_SEQ_DEPTH 32
`define ISC_OFFSET_MAX 12'd3071
`define ISC_CYCLES_MAX 13'd7999
`define ISC_OFFSET_HZ 24576000
`define ISC_CLK_HZ 125000000
`endif

// *** logic/isc_counters.v ***
/*
 image signature counters: frame and trigger tallies, 48-byte signature
 generator on the pixel byte stream, led blanking control.
 assumes strobe and trigger pins are asynchronous, register port and pixel
 path are on clock_i, and nv storage sits outside behind led_nv ports.
*/
// Strobed register access is this design's own decision.
// Behaviour
// - frame tally counts each sensor frame
// - frame reset bit clears tally, self-clears
// - frame tally in signature bytes 5-8
// - host reads both tallies directly
// - trigger tally counts external triggers
// - trigger reset bit clears tally, self-clears
// - trigger tally in signature bytes 9-12
// - trigger view mirrors shared signature settings
// - four output states in bytes 29-32
// - two input states in 33-34, reserved after
// - sequence index byte 37, 38-40 zero
// - serial number in bytes 41-44
// - user word in bytes 45-48
// - signature is 48 bytes, ascending order
// - led blank suppresses status, not errors
// - led blank kept in nonvolatile storage
// - startup and errors override led blanking
// - cycle time nested offset/cycles/seconds counter
// - signature inserted while enabled
// - line select: top, bottom negative, padding
// - per sequence entry user word
`timescale 1ns/100ps
`include "isc_defines.vh"
module isc_counters (
  input wire clock_i,
  input wire resetn_i,
  input wire enable_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire write_i,
  input wire read_i,
  output reg [31:0] rdata_o,
  input wire sensor_frame_strobe_i,
  input wire ext_trigger_i,
  input wire integration_start_i,
  input wire line_start_i,
  input wire pixel_valid_i,
  input wire [7:0] pixel_i,
  input wire [15:0] image_height_i,
  input wire [15:0] aoi_left_i,
  input wire [15:0] aoi_top_i,
  input wire [15:0] aoi_width_i,
  input wire [15:0] aoi_height_i,
  input wire [31:0] shutter_i,
  input wire [15:0] gain_i,
  input wire [31:0] output_states_i,
  input wire [15:0] input_states_i,
  input wire [4:0] sequence_entry_index_i,
  input wire sequence_mode_i,
  input wire [31:0] serial_number_i,
  input wire startup_i,
  input wire error_i,
  input wire [2:0] status_led_i,
  input wire led_nv_load_i,
  input wire led_nv_value_i,
  output reg led_nv_write_o,
  output reg led_nv_value_o,
  output reg [2:0] led_o,
  output reg pixel_valid_o,
  output reg [7:0] pixel_o
);
  // synchronisers: first stage read only by second stage
  reg [1:0] fs_sync_q;
  reg [1:0] tr_sync_q;
  reg fs_last_q;
  reg tr_last_q;
  reg [31:0] frame_tally_q;
  reg [31:0] trig_tally_q;
  reg sig_on_q;
  reg [15:0] signature_line_q;
  reg led_blank_q;
  reg [31:0] user_word_q [0:`ISC_SEQ_DEPTH-1];
  reg [4:0] user_sel_q;
  reg [11:0] cyc_offset_q;
  reg [12:0] cyc_cycles_q;
  reg [6:0] cyc_seconds_q;
  reg [27:0] frac_q;
  reg [31:0] cycle_snap_q;
  reg [15:0] line_cnt_q;
  reg [5:0] byte_idx_q;
  reg in_sig_q;
  reg [7:0] sig_byte;
  wire fs_rise;
  wire tr_rise;
  wire [31:0] cycle_time;
  wire [15:0] target_line;
  wire [4:0] user_idx;
  wire frame_reset;
  wire trig_reset;
  wire [28:0] frac_sum;
  wire offset_tick;
  integer i;

  // sets word bit 31, which is the msb of the 32-bit word
  function [31:0] isc_hi_bit;
    input b;
    begin
      isc_hi_bit = {b, 31'h0};
    end
  endfunction

  function [7:0] isc_pick;
    input [31:0] w;
    input [1:0] k;
    begin
      isc_pick = w[k*8 +: 8];
    end
  endfunction

  assign fs_rise = fs_sync_q[1] & ~fs_last_q;
  assign tr_rise = tr_sync_q[1] & ~tr_last_q;
  assign frame_reset = write_i && addr_i == `ISC_OFS_FRAME_CTRL &&
    wdata_i[`ISC_BIT_RESET];
  assign trig_reset = write_i && addr_i == `ISC_OFS_TRIG_CTRL &&
    wdata_i[`ISC_BIT_RESET];
  assign cycle_time = {cyc_seconds_q, cyc_cycles_q, cyc_offset_q};
  // negative line counts from the bottom; height itself is padding
  assign target_line = signature_line_q[15] ?
    image_height_i + signature_line_q : signature_line_q;
  assign user_idx = sequence_mode_i ? sequence_entry_index_i : 5'h0;
  // fractional accumulator turns 125 mhz into the 24.576 mhz offset tick
  assign frac_sum = {1'b0, frac_q} + 29'd24576000;
  assign offset_tick = frac_sum >= 29'd125000000;

  // edge memory resets low like the idle pins, so reset shows no edge
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      fs_sync_q <= 2'h0;
      tr_sync_q <= 2'h0;
      fs_last_q <= 1'b0;
      tr_last_q <= 1'b0;
    end else if (enable_i) begin
      fs_sync_q <= {fs_sync_q[0], sensor_frame_strobe_i};
      tr_sync_q <= {tr_sync_q[0], ext_trigger_i};
      fs_last_q <= fs_sync_q[1];
      tr_last_q <= tr_sync_q[1];
    end
  end

  // tallies; reset write wins over a same-cycle count
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      frame_tally_q <= 32'h0;
      trig_tally_q <= 32'h0;
    end else if (enable_i) begin
      if (frame_reset)
        frame_tally_q <= 32'h0;
      else if (fs_rise)
        frame_tally_q <= frame_tally_q + 32'h1;
      if (trig_reset)
        trig_tally_q <= 32'h0;
      else if (tr_rise)
        trig_tally_q <= trig_tally_q + 32'h1;
    end
  end

  // cycle time nested counter
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      frac_q <= 28'h0;
      cyc_offset_q <= 12'h0;
      cyc_cycles_q <= 13'h0;
      cyc_seconds_q <= 7'h0;
      cycle_snap_q <= 32'h0;
    end else if (enable_i) begin
      // the remainder carries over, so the mean tick rate stays exact
      frac_q <= offset_tick ? frac_sum[27:0] - 28'd125000000 :
        frac_sum[27:0];
      if (offset_tick) begin
        if (cyc_offset_q == `ISC_OFFSET_MAX) begin
          cyc_offset_q <= 12'h0;
          if (cyc_cycles_q == `ISC_CYCLES_MAX) begin
            cyc_cycles_q <= 13'h0;
            cyc_seconds_q <= cyc_seconds_q + 7'h1;
          end else begin
            cyc_cycles_q <= cyc_cycles_q + 13'h1;
          end
        end else begin
          cyc_offset_q <= cyc_offset_q + 12'h1;
        end
      end
      if (integration_start_i)
        cycle_snap_q <= cycle_time;
    end
  end

  // register writes; the reset bits are never stored, so they self-clear
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      sig_on_q <= 1'b0;
      signature_line_q <= 16'h0;
      user_sel_q <= 5'h0;
      led_blank_q <= 1'b0;
      led_nv_write_o <= 1'b0;
      led_nv_value_o <= 1'b0;
      for (i = 0; i < `ISC_SEQ_DEPTH; i = i + 1)
        user_word_q[i] <= 32'h0;
    end else if (enable_i) begin
      led_nv_write_o <= 1'b0;
      // a host write in the same cycle comes later, so it wins over a load
      if (led_nv_load_i)
        led_blank_q <= led_nv_value_i;
      if (write_i) begin
        case (addr_i)
          // the trigger control view mirrors the shared fields
          `ISC_OFS_SIG_CTRL, `ISC_OFS_TRIG_CTRL: begin
            sig_on_q <= wdata_i[`ISC_BIT_SIG_ON];
            signature_line_q <= wdata_i[15:0];
          end
          `ISC_OFS_USER_WORD:
            user_word_q[user_sel_q] <= wdata_i;
          `ISC_OFS_SEQ_SEL:
            user_sel_q <= wdata_i[4:0];
          `ISC_OFS_FEATURE_CTRL: begin
            led_blank_q <= wdata_i[`ISC_BIT_LED_BLANK];
            led_nv_write_o <= 1'b1;
            led_nv_value_o <= wdata_i[`ISC_BIT_LED_BLANK];
          end
          default: ;
        endcase
      end
    end
  end

  // read port; frame control reads only its presence bit
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0;
    end else if (enable_i) begin
      rdata_o <= 32'h0;
      if (read_i) begin
        case (addr_i)
          `ISC_OFS_FRAME_CTRL:
            rdata_o <= isc_hi_bit(1'b1);
          `ISC_OFS_FRAME_VAL:
            rdata_o <= frame_tally_q;
          `ISC_OFS_TRIG_CTRL, `ISC_OFS_SIG_CTRL:
            rdata_o <= isc_hi_bit(1'b1) |
              ({31'h0, sig_on_q} << `ISC_BIT_SIG_ON) |
              {16'h0, signature_line_q};
          `ISC_OFS_TRIG_VAL:
            rdata_o <= trig_tally_q;
          `ISC_OFS_USER_WORD:
            rdata_o <= user_word_q[user_sel_q];
          `ISC_OFS_SEQ_SEL:
            rdata_o <= {27'h0, user_sel_q};
          `ISC_OFS_FEATURE_CTRL:
            rdata_o <= isc_hi_bit(1'b1) |
              ({31'h0, 1'b1} << `ISC_BIT_LED_INQ) |
              ({31'h0, led_blank_q} << `ISC_BIT_LED_BLANK);
          default:
            rdata_o <= 32'h0;
        endcase
      end
    end
  end

  // signature byte table, ascending byte order
  always @* begin
    case (byte_idx_q)
      6'd0, 6'd1, 6'd2, 6'd3:
        sig_byte = isc_pick(cycle_snap_q, byte_idx_q[1:0]);
      6'd4, 6'd5, 6'd6, 6'd7:
        sig_byte = isc_pick(frame_tally_q, byte_idx_q[1:0]);
      6'd8, 6'd9, 6'd10, 6'd11:
        sig_byte = isc_pick(trig_tally_q, byte_idx_q[1:0]);
      6'd12, 6'd13, 6'd14, 6'd15:
        sig_byte = isc_pick({aoi_top_i, aoi_left_i},
          byte_idx_q[1:0]);
      6'd16, 6'd17, 6'd18, 6'd19:
        sig_byte = isc_pick({aoi_height_i, aoi_width_i},
          byte_idx_q[1:0]);
      6'd20, 6'd21, 6'd22, 6'd23:
        sig_byte = isc_pick(shutter_i, byte_idx_q[1:0]);
      6'd24, 6'd25, 6'd26, 6'd27:
        sig_byte = isc_pick({16'h0, gain_i}, byte_idx_q[1:0]);
      6'd28, 6'd29, 6'd30, 6'd31:
        sig_byte = isc_pick(output_states_i, byte_idx_q[1:0]);
      6'd32, 6'd33, 6'd34, 6'd35:
        sig_byte = isc_pick({16'h0, input_states_i},
          byte_idx_q[1:0]);
      6'd36, 6'd37, 6'd38, 6'd39:
        sig_byte = isc_pick({27'h0, sequence_entry_index_i},
          byte_idx_q[1:0]);
      6'd40, 6'd41, 6'd42, 6'd43:
        sig_byte = isc_pick(serial_number_i, byte_idx_q[1:0]);
      6'd44, 6'd45, 6'd46, 6'd47:
        sig_byte = isc_pick(user_word_q[user_idx], byte_idx_q[1:0]);
      default:
        sig_byte = 8'h0;
    endcase
  end

  // pixel path: one stage of latency, signature replaces leading bytes
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      line_cnt_q <= 16'h0;
      byte_idx_q <= 6'h0;
      in_sig_q <= 1'b0;
      pixel_valid_o <= 1'b0;
      pixel_o <= 8'h0;
    end else if (enable_i) begin
      pixel_valid_o <= pixel_valid_i;
      pixel_o <= pixel_i;
      if (fs_rise)
        line_cnt_q <= 16'h0;
      // a line shorter than the signature is cut; the next line start ends it
      if (line_start_i) begin
        byte_idx_q <= 6'h0;
        // padding line is only hit if the stream carries it
        in_sig_q <= sig_on_q && line_cnt_q == target_line;
        line_cnt_q <= line_cnt_q + 16'h1;
      end else if (pixel_valid_i && in_sig_q) begin
        pixel_o <= sig_byte;
        if (byte_idx_q == `ISC_SIG_BYTES - 1)
          in_sig_q <= 1'b0;
        byte_idx_q <= byte_idx_q + 6'h1;
      end
    end
  end

  // led: blanking hides status, never startup or error indication
  always @(posedge clock_i) begin
    if (!resetn_i)
      led_o <= 3'h0;
    else if (enable_i)
      led_o <= (led_blank_q && !startup_i && !error_i) ?
        3'h0 : status_led_i;
  end
endmodule

// *** dv/isc_counters_asserts.sv ***
/*
 checker for isc_counters: register port, pixel path, led and nv outputs.
 assumes enable_i is high whenever the register port or pixels are used.
*/
`timescale 1ns/100ps
`include "isc_defines.vh"
module isc_counters_chk (
  input wire clock_i,
  input wire resetn_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire write_i,
  input wire read_i,
  input wire [31:0] rdata_o,
  input wire pixel_valid_i,
  input wire [7:0] pixel_i,
  input wire pixel_valid_o,
  input wire [7:0] pixel_o,
  input wire startup_i,
  input wire error_i,
  input wire [2:0] status_led_i,
  input wire led_nv_write_o,
  input wire led_nv_value_o,
  input wire [2:0] led_o
);
  reg on_q;
  reg [15:0] line_q;
  // both control words write the one shared signature setting
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      on_q <= 1'b0;
      line_q <= 16'h0;
    end else if (write_i && (addr_i == `ISC_OFS_SIG_CTRL ||
        addr_i == `ISC_OFS_TRIG_CTRL)) begin
      on_q <= wdata_i[`ISC_BIT_SIG_ON];
      line_q <= wdata_i[15:0];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rd(a);
    read_i && addr_i == a;
  endsequence
  a_rd_idle: assert property (!read_i |=> rdata_o == 32'h0)
    else $error("rdata not idle");
  a_unmapped_zero: assert property (read_i &&
    addr_i[31:8] != 24'hf10006 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_frm_ctrl_bits: assert property (s_rd(`ISC_OFS_FRAME_CTRL) ##0
    !$past(write_i) |=> rdata_o == 32'h80000000)
    else $error("frame control bits wrong");
  a_trig_mirror: assert property (s_rd(`ISC_OFS_TRIG_CTRL) |=>
    rdata_o == {6'h20, $past(on_q), 9'h0, $past(line_q)})
    else $error("trigger control mirror wrong");
  a_pix_valid: assert property (pixel_valid_o == $past(pixel_valid_i))
    else $error("pixel valid delay wrong");
  a_pix_plain: assert property ($past(pixel_valid_i && !on_q) |->
    pixel_o == $past(pixel_i))
    else $error("pixel changed while signature off");
  a_nv_store: assert property (write_i &&
    addr_i == `ISC_OFS_FEATURE_CTRL |=> led_nv_write_o &&
    led_nv_value_o == $past(wdata_i[`ISC_BIT_LED_BLANK]))
    else $error("led setting not stored");
  a_led_err: assert property ($past(startup_i || error_i) |->
    led_o == $past(status_led_i))
    else $error("led not normal in startup or error");
endmodule
bind isc_counters isc_counters_chk u_chk (.clock_i, .resetn_i, .addr_i,
  .wdata_i, .write_i, .read_i, .rdata_o, .pixel_valid_i, .pixel_i,
  .pixel_valid_o, .pixel_o, .startup_i, .error_i, .status_led_i,
  .led_nv_write_o, .led_nv_value_o, .led_o);

// *** dv/isc_sensor_model.sv ***
/*
 sensor readout model: on go_i one frame strobe, three lines of fifty bytes.
 assumes go_i is a one-cycle pulse given only while idle.
*/
`timescale 1ns/100ps
module isc_sensor_model (
  input wire clock_i,
  input wire go_i,
  output reg frame_o,
  output reg line_o,
  output reg valid_o,
  output reg [7:0] data_o
);
  reg [7:0] cnt;
  initial begin
    frame_o = 1'b0;
    line_o = 1'b0;
    valid_o = 1'b0;
    data_o = 8'h0;
  end
  // idle bytes keep toggling so a stale pass-through shows up
  always begin
    @(posedge clock_i);
    data_o <= ~data_o;
    if (go_i) begin
      frame_o <= 1'b1;
      cnt = 8'h0;
      repeat (4) @(posedge clock_i);
      repeat (3) begin
        line_o <= 1'b1;
        data_o <= ~cnt;
        @(posedge clock_i);
        line_o <= 1'b0;
        repeat (50) begin
          valid_o <= 1'b1;
          data_o <= cnt;
          cnt = cnt + 8'h1;
          @(posedge clock_i);
        end
        valid_o <= 1'b0;
      end
      frame_o <= 1'b0;
    end
  end
endmodule

// *** dv/isc_counters_test.sv ***
/*
 self-checking bench for isc_counters: registers, tallies, signature line,
 led blanking. assumes isc_sensor_model feeds the pixel side.
*/
`timescale 1ns/100ps
`include "isc_defines.vh"
module isc_counters_test;
  reg clk, rstn, wr_s, rd_s, tg, go, stup, err, ld, sq, en;
  reg [31:0] addr, wdata;
  reg [4:0] idx;
  reg [191:0] cfg;
  reg [383:0] sig;
  reg [63:0] rows [0:5];
  reg [7:0] cap [0:255];
  reg [7:0] cap_n;
  wire [31:0] rdata;
  wire frm, ln, pv, pvo;
  wire [7:0] px, pxo;
  wire [2:0] led;
  integer n_fail, cmp_count, k;
  always #4 clk = ~clk;
  isc_sensor_model sen (.clock_i(clk), .go_i(go), .frame_o(frm),
    .line_o(ln), .valid_o(pv), .data_o(px));
  isc_counters dut (.clock_i(clk), .resetn_i(rstn), .enable_i(en),
    .addr_i(addr), .wdata_i(wdata), .write_i(wr_s), .read_i(rd_s),
    .rdata_o(rdata), .sensor_frame_strobe_i(frm), .ext_trigger_i(tg),
    .integration_start_i(go), .line_start_i(ln), .pixel_valid_i(pv),
    .pixel_i(px), .image_height_i(16'h3), .aoi_left_i(cfg[15:0]),
    .aoi_top_i(cfg[31:16]), .aoi_width_i(cfg[47:32]),
    .aoi_height_i(cfg[63:48]), .shutter_i(cfg[95:64]),
    .gain_i(cfg[111:96]), .output_states_i(cfg[143:112]),
    .input_states_i(cfg[159:144]), .sequence_entry_index_i(idx),
    .sequence_mode_i(sq), .serial_number_i(cfg[191:160]),
    .startup_i(stup), .error_i(err), .status_led_i(3'h5),
    .led_nv_load_i(ld), .led_nv_value_i(1'b0), .led_nv_write_o(),
    .led_nv_value_o(), .led_o(led), .pixel_valid_o(pvo), .pixel_o(pxo));
  always @(posedge clk) if (go) cap_n <= 8'h0;
    else if (pvo) begin
      cap[cap_n] <= pxo;
      cap_n <= cap_n + 8'h1;
    end
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("FAIL %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [31:0] a, input [31:0] e);
    begin
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  task frame;
    integer i;
    begin
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      i = 0;
      @(posedge clk);
      while (frm && i < 400) begin
        @(posedge clk);
        i = i + 1;
      end
      chk(frm, 1'b0);
      repeat (4) @(posedge clk);
    end
  endtask
  task pulse(input integer n);
    repeat (n) begin
      @(posedge clk);
      tg <= 1'b1;
      repeat (3) @(posedge clk);
      tg <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task stop_test;
    begin
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    stop_test;
  end
  initial begin
    {clk, rstn, wr_s, rd_s, tg, go, stup, err, ld, sq} = 10'h0;
    en = 1'b1;
    {addr, wdata, idx, cap_n, n_fail, cmp_count} = 0;
    cfg = 192'h2c2b2a29_6655_44332211_0a09_08070605_1817_1615_1413_1211;
    rows[0] = {`ISC_OFS_FRAME_CTRL, 32'h80000000};
    rows[1] = {`ISC_OFS_FRAME_VAL, 32'h0};
    rows[2] = {`ISC_OFS_TRIG_CTRL, 32'h80000000};
    rows[3] = {`ISC_OFS_TRIG_VAL, 32'h0};
    rows[4] = {`ISC_OFS_FEATURE_CTRL, 32'hc0000000};
    rows[5] = {32'hf1000700, 32'h0};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    wr(`ISC_OFS_FRAME_VAL, 32'hffffffff);
    for (k = 0; k < 6; k = k + 1)
      rd(rows[k][63:32], rows[k][31:0]);
    frame;
    frame;
    rd(`ISC_OFS_FRAME_VAL, 32'h2);
    pulse(5);
    rd(`ISC_OFS_TRIG_VAL, 32'h5);
    wr(`ISC_OFS_FRAME_CTRL, 32'h40000000);
    wr(`ISC_OFS_TRIG_CTRL, 32'h40000000);
    rd(`ISC_OFS_FRAME_VAL, 32'h0);
    rd(`ISC_OFS_TRIG_VAL, 32'h0);
    rd(`ISC_OFS_FRAME_CTRL, 32'h80000000);
    pulse(2);
    wr(`ISC_OFS_SEQ_SEL, 32'h3);
    wr(`ISC_OFS_USER_WORD, 32'h3c3b3a39);
    sq <= 1'b1;
    idx <= 5'h3;
    wr(`ISC_OFS_SIG_CTRL, 32'h02000001);
    rd(`ISC_OFS_TRIG_CTRL, 32'h82000001);
    frame;
    sig = {32'h3c3b3a39, cfg[191:160], 24'h0, 8'h3, 16'h0, cfg[159:112],
      16'h0, cfg[111:0], 32'h2, 32'h1, 32'h0};
    for (k = 4; k < 28; k = k + 1)
      chk(cap[50 + k], sig[8 * k +: 8]);
    for (k = 28; k < 48; k = k + 1)
      chk(cap[50 + k], sig[8 * k +: 8]);
    chk({cap[51][3:0], cap[50]} <= 12'd3071, 1);
    chk({cap[53][0], cap[52], cap[51][7:4]} <= 13'd7999, 1);
    chk(cap[98], 98);
    chk(cap[4], 4);
    wr(`ISC_OFS_SIG_CTRL, 32'h0200ffff);
    frame;
    chk(cap[104], 2);
    chk(cap[54], 54);
    wr(`ISC_OFS_FEATURE_CTRL, 32'h00004000);
    rd(`ISC_OFS_FEATURE_CTRL, 32'hc0004000);
    chk(led, 0);
    @(posedge clk);
    err <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(led, 5);
    @(posedge clk);
    {err, stup} <= 2'b01;
    repeat (2) @(posedge clk);
    #1 chk(led, 5);
    @(posedge clk);
    {stup, ld} <= 2'b01;
    @(posedge clk);
    ld <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(led, 5);
    @(posedge clk);
    en <= 1'b0;
    pulse(3);
    en <= 1'b1;
    rd(`ISC_OFS_TRIG_VAL, 32'h2);
    wr(`ISC_OFS_FEATURE_CTRL, 32'h00004000);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k < 6; k = k + 1)
      rd(rows[k][63:32], rows[k][31:0]);
    stop_test;
  end
endmodule
